// *** ddc_port.sv ***
// Serial command port of a dual current DAC: two wire write slave or
// three wire shift slave, selected by a strap pin
// Assumes all pins are asynchronous to i_clk, which runs far faster than the link
module ddc_port
   import ddc_pkg::*;
(
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst,
   // Mode strap
   input  wire logic i_spi_select,
   // Serial clock and data, data is open drain in two wire mode
   input  wire logic i_sclk,
   input  wire logic i_sdata,
   output logic      o_sdata,
   output logic      o_sdata_oe_n,
   // Chip select in SPI mode, address select low in two wire mode
   input  wire logic i_cs_n_addr_select_low,
   // Address select high in two wire mode
   input  wire logic i_addr_select_high,
   // DAC settings
   output ddc_chan_t o_channel_a,
   output ddc_chan_t o_channel_b,
   output logic      o_ref_internal,
   // Status
   output logic      o_exec
);
   logic       scl;
   logic       scl_rise;
   logic       scl_fall;
   logic       sda;
   logic       sda_rise;
   logic       sda_fall;
   logic       cs_n;
   logic       cs_rise;
   logic       cs_fall;
   logic       mode_spi;
   logic       mode_meta;
   logic       ash_meta;
   logic       addr_high;
   logic       start_seen;
   logic       stop_seen;
   ddc_state_t state;
   logic [3:0] bit_cnt;
   logic [1:0] byte_idx;
   logic [7:0] shift8;
   logic [15:0] i2c_word;
   logic [15:0] spi_word;
   logic [4:0] spi_cnt;
   logic       spi_active;
   logic       ack_drive;
   logic       i2c_exec;
   logic       spi_exec;
   ddc_frame_t frame;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   ddc_sync u_scl (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_pin   (i_sclk),
      .o_level (scl),
      .o_rise  (scl_rise),
      .o_fall  (scl_fall)
   );

   ddc_sync u_sda (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_pin   (i_sdata),
      .o_level (sda),
      .o_rise  (sda_rise),
      .o_fall  (sda_fall)
   );

   ddc_sync u_cs (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_pin   (i_cs_n_addr_select_low),
      .o_level (cs_n),
      .o_rise  (cs_rise),
      .o_fall  (cs_fall)
   );

   // ----------------------------------------
   // Strap and address pin synchronisers
   // ----------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         mode_meta <= 1'b0;
         mode_spi  <= 1'b0;
         ash_meta  <= 1'b0;
         addr_high <= 1'b0;
      end else begin
         mode_meta <= i_spi_select;
         mode_spi  <= mode_meta;
         ash_meta  <= i_addr_select_high;
         addr_high <= ash_meta;
      end
   end

   // ----------------------------------------
   // Bus conditions, only in two wire mode
   // ----------------------------------------
   assign start_seen = ~mode_spi & scl & sda_fall;
   assign stop_seen  = ~mode_spi & scl & sda_rise;

   // ----------------------------------------
   // Two wire receiver
   // ----------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state     <= DDC_IDLE;
         bit_cnt   <= 4'h0;
         byte_idx  <= 2'h0;
         shift8    <= 8'h00;
         i2c_word  <= 16'h0000;
         ack_drive <= 1'b0;
         i2c_exec  <= 1'b0;
      end else begin
         i2c_exec <= 1'b0;
         if (mode_spi) begin
            state     <= DDC_IDLE;
            ack_drive <= 1'b0;
         end else if (stop_seen) begin
            state     <= DDC_IDLE;
            ack_drive <= 1'b0;
         end else if (start_seen) begin
            state     <= DDC_ADDR;
            bit_cnt   <= 4'h0;
            byte_idx  <= 2'h0;
            ack_drive <= 1'b0;
         end else begin
            case (state)
               DDC_IDLE: begin
                  ack_drive <= 1'b0;
               end
               DDC_ADDR, DDC_DATA: begin
                  if (scl_rise) begin
                     shift8  <= {shift8[6:0], sda};
                     bit_cnt <= bit_cnt + 4'h1;
                     if (state == DDC_DATA && byte_idx == 2'h2 && bit_cnt == `DDC_LAST_BIT) begin
                        i2c_word[7:0] <= {shift8[6:0], sda};
                        i2c_exec      <= 1'b1;
                     end
                  end else if (scl_fall && bit_cnt == `DDC_BYTE_BITS) begin
                     bit_cnt <= 4'h0;
                     if (state == DDC_ADDR) begin
                        if (shift8 == {`DDC_ADDR_HIGH, addr_high, i_addr_low_q(), 1'b0}) begin
                           state     <= DDC_AACK;
                           ack_drive <= 1'b1;
                        end else begin
                           state <= DDC_SKIP;
                        end
                     end else begin
                        state     <= DDC_DACK;
                        ack_drive <= 1'b1;
                        if (byte_idx == 2'h1) begin
                           i2c_word[15:8] <= shift8;
                        end else begin
                           i2c_word[7:0] <= shift8;
                        end
                     end
                  end
               end
               DDC_AACK, DDC_DACK: begin
                  if (scl_fall) begin
                     ack_drive <= 1'b0;
                     if (state == DDC_DACK && byte_idx == 2'h2) begin
                        state <= DDC_SKIP;
                     end else begin
                        state    <= DDC_DATA;
                        byte_idx <= byte_idx + 2'h1;
                     end
                  end
               end
               DDC_SKIP: begin
                  ack_drive <= 1'b0;
               end
               default: begin
                  state <= DDC_IDLE;
               end
            endcase
         end
      end
   end

   // Address select low shares the chip select pin
   function automatic logic i_addr_low_q();
      return cs_n;
   endfunction

   // ----------------------------------------
   // Open drain data output
   // ----------------------------------------
   assign o_sdata      = 1'b0;
   assign o_sdata_oe_n = ~(ack_drive & ~mode_spi);

   // ----------------------------------------
   // Three wire shifter
   // ----------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         spi_word   <= 16'h0000;
         spi_cnt    <= 5'h00;
         spi_active <= 1'b0;
         spi_exec   <= 1'b0;
      end else begin
         spi_exec <= 1'b0;
         if (!mode_spi) begin
            spi_active <= 1'b0;
         end else if (cs_fall) begin
            spi_active <= 1'b1;
            spi_cnt    <= 5'h00;
         end else if (cs_rise) begin
            spi_active <= 1'b0;
            spi_exec   <= spi_active & (spi_cnt >= `DDC_SPI_BITS);
         end else if (spi_active && !cs_n && scl_rise) begin
            spi_word <= {spi_word[14:0], sda};
            if (spi_cnt != 5'h1f) begin
               spi_cnt <= spi_cnt + 5'h01;
            end
         end
      end
   end

   // ----------------------------------------
   // Frame select and decoder
   // ----------------------------------------
   assign frame  = mode_spi ? ddc_frame_t'(spi_word) : ddc_frame_t'(i2c_word);
   assign o_exec = i2c_exec | spi_exec;

   ddc_decoder u_dec (
      .i_clk          (i_clk),
      .i_rst          (i_rst),
      .i_exec         (o_exec),
      .i_frame        (frame),
      .o_channel_a    (o_channel_a),
      .o_channel_b    (o_channel_b),
      .o_ref_internal (o_ref_internal)
   );
endmodule

// *** ddc_consts.svh ***
// Constants of the dual DAC serial command port
// Assumes inclusion by the package and the modules that need the figures
`ifndef DDC_CONSTS_SVH
`define DDC_CONSTS_SVH
// ----------------------------------------
// Address and frame layout
// ----------------------------------------
`define DDC_ADDR_HIGH      5'b01100
`define DDC_CMD_W          6
`define DDC_CODE_W         10
`define DDC_FRAME_W        16
`define DDC_BYTE_BITS      4'h8
`define DDC_LAST_BIT       4'h7
`define DDC_SPI_BITS       5'h10
// ----------------------------------------
// Command codes
// ----------------------------------------
`define DDC_C_NOP          6'h00
`define DDC_C_LOAD_BOTH    6'h01
`define DDC_C_LOAD_A       6'h02
`define DDC_C_LOAD_B       6'h03
`define DDC_C_IN_BOTH      6'h04
`define DDC_C_IN_A         6'h05
`define DDC_C_IN_B         6'h06
`define DDC_C_UPD_BOTH     6'h07
`define DDC_C_UPD_A        6'h09
`define DDC_C_UPD_B        6'h0a
`define DDC_C_REF_INT      6'h0b
`define DDC_C_REF_EXT      6'h0c
`define DDC_C_SHDN_BOTH    6'h0d
`define DDC_C_SHDN_A       6'h0e
`define DDC_C_SHDN_B       6'h0f
`define DDC_C_PWR_BOTH     6'h2d
`define DDC_C_PWR_A        6'h2e
`define DDC_C_PWR_B        6'h2f
`define DDC_C_RANGE_A      3'b010
`define DDC_C_RANGE_B      3'b110
`define DDC_RANGE_MAX      3'h5
// ----------------------------------------
// Reset values
// ----------------------------------------
`define DDC_RST_CODE       10'h000
`define DDC_RST_RANGE      3'h0
`define DDC_RST_REF_INT    1'b0
`define DDC_RST_SHDN       1'b0
`endif

// *** ddc_pkg.sv ***
// Types of the dual DAC serial command port
// Assumes ddc_consts.svh is on the include path
package ddc_pkg;
`include "ddc_consts.svh"
   // ----------------------------------------
   // Decoded frame
   // ----------------------------------------
   typedef struct packed {
      logic [`DDC_CMD_W-1:0]  command_bits;
      logic [`DDC_CODE_W-1:0] code_bits;
   } ddc_frame_t;
   // ----------------------------------------
   // Per channel settings
   // ----------------------------------------
   typedef struct packed {
      logic [`DDC_CODE_W-1:0] input_code;
      logic [`DDC_CODE_W-1:0] dac_code;
      logic [2:0]             full_scale_current;
      logic                   shutdown;
   } ddc_chan_t;
   // ----------------------------------------
   // Two wire receiver states, Gray along the path
   // ----------------------------------------
   typedef enum logic [2:0] {
      DDC_IDLE = 3'b000,
      DDC_ADDR = 3'b001,
      DDC_AACK = 3'b011,
      DDC_DATA = 3'b010,
      DDC_DACK = 3'b110,
      DDC_SKIP = 3'b111
   } ddc_state_t;
endpackage

// *** ddc_sync.sv ***
// Two flip-flop synchroniser with edge detection
// Assumes the input is asynchronous to i_clk
module ddc_sync
   import ddc_pkg::*;
(
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst,
   // Pin and result
   input  wire logic i_pin,
   output logic      o_level,
   output logic      o_rise,
   output logic      o_fall
);
   logic meta;
   logic stable;
   logic prev;

   // ----------------------------------------
   // Synchroniser and edge finder
   // ----------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         meta   <= 1'b1;
         stable <= 1'b1;
         prev   <= 1'b1;
      end else begin
         meta   <= i_pin;
         stable <= meta;
         prev   <= stable;
      end
   end

   assign o_level = stable;
   assign o_rise  = stable & ~prev;
   assign o_fall  = ~stable & prev;
endmodule

// *** ddc_decoder.sv ***
// Command decoder holding input, DAC and configuration registers
// Assumes one execute pulse per accepted frame
module ddc_decoder
   import ddc_pkg::*;
(
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   // Frame
   input  wire logic       i_exec,
   input  wire ddc_frame_t i_frame,
   // Settings
   output ddc_chan_t       o_channel_a,
   output ddc_chan_t       o_channel_b,
   output logic            o_ref_internal
);
   ddc_chan_t chan [2];
   logic [5:0] cmd;

   assign cmd = i_frame.command_bits;

   // ----------------------------------------
   // Channel registers
   // ----------------------------------------
   for (genvar g = 0; g < 2; g++) begin : g_chan
      always_ff @(posedge i_clk) begin
         if (i_rst) begin
            chan[g].input_code         <= `DDC_RST_CODE;
            chan[g].dac_code           <= `DDC_RST_CODE;
            chan[g].full_scale_current <= `DDC_RST_RANGE;
            chan[g].shutdown           <= `DDC_RST_SHDN;
         end else if (i_exec) begin
            if (cmd == `DDC_C_LOAD_BOTH || (g == 0 && cmd == `DDC_C_LOAD_A) ||
                (g == 1 && cmd == `DDC_C_LOAD_B)) begin
               chan[g].input_code <= i_frame.code_bits;
               chan[g].dac_code   <= i_frame.code_bits;
            end else if (cmd == `DDC_C_IN_BOTH || (g == 0 && cmd == `DDC_C_IN_A) ||
                         (g == 1 && cmd == `DDC_C_IN_B)) begin
               chan[g].input_code <= i_frame.code_bits;
            end else if (cmd == `DDC_C_UPD_BOTH || (g == 0 && cmd == `DDC_C_UPD_A) ||
                         (g == 1 && cmd == `DDC_C_UPD_B)) begin
               chan[g].dac_code <= chan[g].input_code;
            end else if (cmd == `DDC_C_SHDN_BOTH || (g == 0 && cmd == `DDC_C_SHDN_A) ||
                         (g == 1 && cmd == `DDC_C_SHDN_B)) begin
               chan[g].shutdown <= 1'b1;
            end else if (cmd == `DDC_C_PWR_BOTH || (g == 0 && cmd == `DDC_C_PWR_A) ||
                         (g == 1 && cmd == `DDC_C_PWR_B)) begin
               chan[g].shutdown <= 1'b0;
            end else if (cmd[5:3] == ((g == 0) ? `DDC_C_RANGE_A : `DDC_C_RANGE_B) &&
                         cmd[2:0] <= `DDC_RANGE_MAX) begin
               chan[g].full_scale_current <= cmd[2:0];
            end
            // Any other code leaves the channel alone
         end
      end
   end

   // ----------------------------------------
   // Reference select
   // ----------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_ref_internal <= `DDC_RST_REF_INT;
      end else if (i_exec && cmd == `DDC_C_REF_INT) begin
         o_ref_internal <= 1'b1;
      end else if (i_exec && cmd == `DDC_C_REF_EXT) begin
         o_ref_internal <= 1'b0;
      end
   end

   assign o_channel_a = chan[0];
   assign o_channel_b = chan[1];
endmodule

// *** ddc_port_chk.sv ***
// Checker of the serial command port outputs
// Assumes binding to ddc_port with a bench driving every pin
module ddc_port_chk
   import ddc_pkg::*;
(
   // Clock and reset
   input wire logic      i_clk,
   input wire logic      i_rst,
   // Pins
   input wire logic      i_spi_select,
   input wire logic      i_sclk,
   input wire logic      i_sdata,
   input wire logic      o_sdata,
   input wire logic      o_sdata_oe_n,
   input wire logic      i_cs_n_addr_select_low,
   input wire logic      i_addr_select_high,
   // Settings
   input wire ddc_chan_t o_channel_a,
   input wire ddc_chan_t o_channel_b,
   input wire logic      o_ref_internal,
   input wire logic      o_exec
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_sdata_zero: assert property (o_sdata == 1'b0)
      else $error("data pin driven high");
   a_ack_scl_low: assert property ($fell(o_sdata_oe_n) |-> !i_sclk)
      else $error("ack begins while clock high");
   a_ack_hold: assert property ($fell(o_sdata_oe_n) |-> (!o_sdata_oe_n)[*6] ##[1:4] o_sdata_oe_n)
      else $error("ack length wrong");
   a_no_ack_spi: assert property (i_spi_select && $past(i_spi_select, 4) |-> o_sdata_oe_n)
      else $error("ack driven in shift mode");
   a_exec_pulse: assert property (o_exec |=> (!o_exec)[*4])
      else $error("execute pulse too long");
   a_exec_scl: assert property (o_exec && !i_spi_select |-> i_sclk && o_sdata_oe_n)
      else $error("execute outside the last data clock");
   a_exec_cs: assert property (o_exec && i_spi_select |-> i_cs_n_addr_select_low && $past(i_cs_n_addr_select_low, 2))
      else $error("execute without select high");
   a_out_cause: assert property ($changed({o_channel_a, o_channel_b, o_ref_internal}) |-> $past(o_exec))
      else $error("settings changed without execute");
   a_reset_dflt: assert property (disable iff (1'b0) i_rst |=> o_channel_a == '0 && o_channel_b == '0 && !o_ref_internal && o_sdata_oe_n && !o_exec)
      else $error("reset values wrong");
   c_ack: cover property ($fell(o_sdata_oe_n));
   c_exec_i2c: cover property (o_exec && !i_spi_select);
   c_exec_spi: cover property (o_exec && i_spi_select);
endmodule

// *** ddc_master.sv ***
// Bus master model for both link modes
// Assumes tasks are called from the bench one at a time
module ddc_master (
   // Clock
   input  wire logic i_clk,
   // Resolved data line
   input  wire logic i_sdata,
   // Master pins
   output logic      o_sclk,
   output logic      o_sdata,
   output logic      o_cs_n
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      o_sclk = 1'b1;
      o_sdata = 1'b1;
      o_cs_n = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   task automatic idle(input bit spi_mode);
      o_sclk <= !spi_mode;
      o_sdata <= 1'b1;
      tick(8);
   endtask
   task automatic start();
      o_sclk <= 1'b0;
      tick(2);
      o_sdata <= 1'b1;
      tick(2);
      o_sclk <= 1'b1;
      tick(4);
      o_sdata <= 1'b0;
      tick(4);
   endtask
   task automatic stop();
      o_sclk <= 1'b0;
      tick(2);
      o_sdata <= 1'b0;
      tick(2);
      o_sclk <= 1'b1;
      tick(4);
      o_sdata <= 1'b1;
      tick(4);
   endtask
   task automatic bit_io(input logic b, output logic s);
      o_sclk <= 1'b0;
      tick(2);
      o_sdata <= b;
      tick(2);
      o_sclk <= 1'b1;
      tick(2);
      s = i_sdata;
      tick(2);
   endtask
   task automatic send(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(b[i], s);
      bit_io(1'b1, s);
      ack = ~s;
   endtask
   task automatic spi(input logic [15:0] w, input int n);
      o_cs_n <= 1'b0;
      tick(4);
      for (int i = 0; i < n; i++) begin
         o_sdata <= w[15 - i];
         tick(4);
         o_sclk <= 1'b1;
         tick(4);
         o_sclk <= 1'b0;
      end
      tick(4);
      o_cs_n <= 1'b1;
      o_sdata <= ~o_sdata;
      tick(8);
   endtask
endmodule

// *** tb.sv ***
// Self-checking bench of the serial command port
// Assumes ddc_pkg, ddc_master and the checker are compiled first
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import ddc_pkg::*;
   logic       i_clk = 1'b0;
   logic       i_rst = 1'b1;
   logic       spi = 1'b0;
   logic       a_low = 1'b0;
   logic       a_high = 1'b1;
   logic       m_sclk, m_sdata, m_cs_n;
   logic       o_sdata, o_sdata_oe_n, o_ref_internal, o_exec, exp_ref;
   ddc_chan_t  o_channel_a, o_channel_b, exp_a, exp_b;
   logic [7:0] n_exec, n_exp;
   logic [2:0] ak;
   int         fails, num_checks;
   wire        sda_bus = m_sdata & (o_sdata_oe_n | o_sdata);
   wire        cs_pin = spi ? m_cs_n : a_low;
   always #50 i_clk = ~i_clk;
   always @(posedge i_clk) n_exec <= i_rst ? 8'h00 : n_exec + {7'h00, o_exec === 1'b1};
   ddc_port DUT (.i_clk(i_clk), .i_rst(i_rst), .i_spi_select(spi), .i_sclk(m_sclk), .i_sdata(sda_bus),
      .o_sdata(o_sdata), .o_sdata_oe_n(o_sdata_oe_n), .i_cs_n_addr_select_low(cs_pin),
      .i_addr_select_high(a_high), .o_channel_a(o_channel_a), .o_channel_b(o_channel_b),
      .o_ref_internal(o_ref_internal), .o_exec(o_exec));
   ddc_master u_master (.i_clk(i_clk), .i_sdata(sda_bus), .o_sclk(m_sclk), .o_sdata(m_sdata), .o_cs_n(m_cs_n));
   task automatic chk(input string nm, input logic [62:0] seen, input logic [62:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic results();
      if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic upd_ch(inout ddc_chan_t ch, input logic [2:0] k, input logic [9:0] d, input logic [2:0] r);
      case (k)
         3'h1: begin
            ch.input_code = d;
            ch.dac_code = d;
         end
         3'h2: ch.input_code = d;
         3'h3: ch.dac_code = ch.input_code;
         3'h4: ch.shutdown = 1'b1;
         3'h5: ch.shutdown = 1'b0;
         3'h6: ch.full_scale_current = r;
         default: ;
      endcase
   endtask
   task automatic upd(input logic [5:0] c, input logic [9:0] d);
      logic [2:0] k;
      logic [1:0] s;
      case (c)
         6'h01, 6'h02, 6'h03: k = 3'h1;
         6'h04, 6'h05, 6'h06: k = 3'h2;
         6'h07, 6'h09, 6'h0a: k = 3'h3;
         6'h0d, 6'h0e, 6'h0f: k = 3'h4;
         6'h2d, 6'h2e, 6'h2f: k = 3'h5;
         default: k = 3'h0;
      endcase
      case (c)
         6'h01, 6'h04, 6'h07, 6'h0d, 6'h2d: s = 2'b11;
         6'h02, 6'h05, 6'h09, 6'h0e, 6'h2e: s = 2'b10;
         default: s = 2'b01;
      endcase
      if (c[4:3] == 2'b10 && c[2:0] <= 3'h5) begin
         k = 3'h6;
         s = c[5] ? 2'b01 : 2'b10;
      end
      if (c == 6'h0b) exp_ref = 1'b1;
      if (c == 6'h0c) exp_ref = 1'b0;
      if (s[1]) upd_ch(exp_a, k, d, c[2:0]);
      if (s[0]) upd_ch(exp_b, k, d, c[2:0]);
   endtask
   task automatic i2c_wr(input logic [7:0] adr, input logic [15:0] w, input int nb, input bit stp, input bit ok);
      ak = 3'b000;
      u_master.start();
      u_master.send(adr, ak[2]);
      if (nb > 1) u_master.send(w[15:8], ak[1]);
      if (nb > 2) u_master.send(w[7:0], ak[0]);
      if (stp) u_master.stop();
      if (ok && nb > 2) begin
         upd(w[15:10], w[9:0]);
         n_exp = n_exp + 8'h01;
      end
   endtask
   task automatic spi_wr(input logic [15:0] w, input int n);
      u_master.spi(w, n);
      if (n == 16) begin
         upd(w[15:10], w[9:0]);
         n_exp = n_exp + 8'h01;
      end
   endtask
   task automatic settle();
      for (int k = 0; k < 16 && n_exec !== n_exp; k++) @(posedge i_clk);
      repeat (2) @(posedge i_clk);
      chk("exec count", {55'h0, n_exec}, {55'h0, n_exp});
      chk("settings", {o_channel_a, o_channel_b, o_ref_internal}, {exp_a, exp_b, exp_ref});
   endtask
   task automatic do_reset();
      i_rst <= 1'b1;
      repeat (8) @(posedge i_clk);
      i_rst <= 1'b0;
      exp_a = '0;
      exp_b = '0;
      exp_ref = 1'b0;
      n_exp = 8'h00;
      repeat (4) @(posedge i_clk);
   endtask
   logic [15:0] tbl [20] = '{16'h13A5, 16'h2400, 16'h1811, 16'h2800, 16'h2C00, 16'h3000, 16'h2C00, 16'h3400,
      16'h06C7, 16'hB800, 16'h3C00, 16'hBC00, 16'h3800, 16'hB400, 16'h0EAA, 16'h1C00, 16'h23FF, 16'hFFFF,
      16'h03FF, 16'h16F0};
   initial begin
      repeat (50000) @(posedge i_clk);
      fails++;
      results();
   end
   initial begin
      do_reset();
      settle();
      i2c_wr(8'h64, 16'h06A5, 3, 1, 1);
      settle();
      chk("acks", {60'h0, ak}, 63'h7);
      i2c_wr(8'h66, 16'h07FF, 3, 1, 0);
      chk("acks", {60'h0, ak}, 63'h0);
      i2c_wr(8'hF0, 16'h07FF, 3, 1, 0);
      chk("acks", {60'h0, ak}, 63'h0);
      a_low <= 1'b1;
      repeat (8) @(posedge i_clk);
      i2c_wr(8'h66, 16'h09C3, 3, 1, 1);
      settle();
      i2c_wr(8'h67, 16'h07FF, 3, 1, 0);
      chk("acks", {60'h0, ak}, 63'h0);
      i2c_wr(8'h66, 16'h07FF, 2, 1, 0);
      chk("acks", {60'h0, ak}, 63'h6);
      settle();
      i2c_wr(8'h66, 16'h0FF0, 2, 0, 0);
      i2c_wr(8'h66, 16'h1555, 3, 0, 1);
      i2c_wr(8'h66, 16'h5400, 3, 1, 1);
      settle();
      a_high <= 1'b0;
      repeat (8) @(posedge i_clk);
      i2c_wr(8'h66, 16'h07FF, 3, 1, 0);
      chk("acks", {60'h0, ak}, 63'h0);
      i2c_wr(8'h62, 16'h0A55, 3, 1, 1);
      chk("acks", {60'h0, ak}, 63'h7);
      settle();
      spi <= 1'b1;
      u_master.idle(1'b1);
      foreach (tbl[i]) begin
         spi_wr(tbl[i], 16);
         settle();
      end
      for (int r = 0; r < 8; r++) begin
         spi_wr({3'b010, 3'(r), 10'h000}, 16);
         spi_wr({3'b110, 3'(7 - r), 10'h000}, 16);
         settle();
      end
      spi_wr(16'h07FF, 15);
      settle();
      do_reset();
      settle();
      results();
   end
endmodule
bind ddc_port ddc_port_chk u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_spi_select(i_spi_select),
   .i_sclk(i_sclk), .i_sdata(i_sdata), .o_sdata(o_sdata), .o_sdata_oe_n(o_sdata_oe_n),
   .i_cs_n_addr_select_low(i_cs_n_addr_select_low), .i_addr_select_high(i_addr_select_high),
   .o_channel_a(o_channel_a), .o_channel_b(o_channel_b), .o_ref_internal(o_ref_internal), .o_exec(o_exec));
